// file: cbsc_pkg.sv
// Shared types, encodings and timing constants of the bus-bias state control
package cbsc_pkg;

    typedef enum logic [2:0] {
        CBSC_MODE_NORMAL    = 3'h0,
        CBSC_MODE_SILENT    = 3'h1,
        CBSC_MODE_STANDBY   = 3'h2,
        CBSC_MODE_GOTOSLEEP = 3'h3,
        CBSC_MODE_SLEEP     = 3'h4
    } cbsc_mode_type;

    typedef enum logic [3:0] {
        CBSC_ST_OFF        = 4'h1,
        CBSC_ST_AUTO_INACT = 4'h2,
        CBSC_ST_AUTO_ACT   = 4'h4,
        CBSC_ST_ACTIVE     = 4'h8
    } cbsc_bias_state_type;

    typedef enum logic [2:0] {
        CBSC_WK_WAIT_DOM  = 3'h1,
        CBSC_WK_WAIT_REC  = 3'h2,
        CBSC_WK_WAIT_DOM2 = 3'h4
    } cbsc_wake_state_type;

    // Undervoltage comparator flags; *_falling high = below falling threshold,
    // *_rising high = above rising threshold
    typedef struct packed {
        logic battery_uv_falling;
        logic battery_uv_rising;
        logic core_supply_uv_falling;
        logic core_supply_uv_rising;
        logic io_supply_uv_falling;
        logic io_supply_uv_rising;
    } cbsc_supply_type;

    // One-hot bias selection of the analog bias network
    typedef struct packed {
        logic floating;
        logic to_ground;
        logic to_2v5;
        logic to_half_supply;
    } cbsc_bias_type;

    typedef struct packed {
        logic dominant;
        logic high_z;
    } cbsc_drive_type;

    localparam int CBSC_CLOCK_PERIOD_NS = 32'h0000_0032;
    localparam int CBSC_BUS_IDLE_TIMEOUT_NS = 32'h000F_4240;
    localparam int CBSC_WAKE_FILTER_NS = 32'h0000_03E8;

    localparam cbsc_bias_type CBSC_BIAS_FLOAT = 4'h8;
    localparam cbsc_bias_type CBSC_BIAS_GND = 4'h4;
    localparam cbsc_bias_type CBSC_BIAS_2V5 = 4'h2;
    localparam cbsc_bias_type CBSC_BIAS_HALF = 4'h1;

    // Least time in ns to whole clock cycles, never below one
    function automatic int cbsc_cycles_at_least(input int ns);
        int c;
        c = (ns + CBSC_CLOCK_PERIOD_NS - 1) / CBSC_CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CBSC_WAKE_FILTER_CYCLES = cbsc_cycles_at_least(CBSC_WAKE_FILTER_NS);
    localparam int CBSC_BUS_IDLE_TIMEOUT_CYCLES = cbsc_cycles_at_least(CBSC_BUS_IDLE_TIMEOUT_NS);

endpackage

// file: cbsc_idle_timer.sv
// Bus-idle timeout counter
`timescale 1ns/10ps
module cbsc_idle_timer
    import cbsc_pkg::*;
#(
    parameter int CYCLES = CBSC_BUS_IDLE_TIMEOUT_CYCLES,
    parameter int W = $clog2(CYCLES + 1)
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_activity,
    output logic o_expired
);

    generate
        if (CYCLES < 1 || W < $clog2(CYCLES + 1)) begin : g_bad
            $error("cbsc_idle_timer: counter cannot hold the timeout");
        end
    endgenerate

    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire at_limit = (cnt_r == LIMIT);

    // Saturating count of quiet cycles, restarted by any activity
    assign cnt_nxt = i_activity ? '0 : (at_limit ? cnt_r : cnt_r + W'(1));

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_expired = at_limit;

endmodule

// file: cbsc_wake_detect.sv
// Remote wake pattern detector on the low-power receiver
`timescale 1ns/10ps
module cbsc_wake_detect
    import cbsc_pkg::*;
#(
    parameter int FILTER = CBSC_WAKE_FILTER_CYCLES,
    parameter int W = $clog2(FILTER + 1)
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_bus_dominant,
    output logic o_wake
);

    generate
        if (FILTER < 1 || W < $clog2(FILTER + 1)) begin : g_bad
            $error("cbsc_wake_detect: filter counter too narrow");
        end
    endgenerate

    localparam logic [W-1:0] LAST = W'(FILTER - 1);

    cbsc_wake_state_type state_r;
    cbsc_wake_state_type state_nxt;
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic wake_r;

    // Level the current phase waits for; other traffic never resets the phase
    wire want = (state_r == CBSC_WK_WAIT_REC) ? !i_bus_dominant : i_bus_dominant;
    wire filtered = i_enable && want && (cnt_r == LAST);
    wire done = filtered && (state_r == CBSC_WK_WAIT_DOM2);

    assign cnt_nxt = (!i_enable || !want || filtered) ? '0 : cnt_r + W'(1);

    always_comb begin
        state_nxt = state_r;
        if (!i_enable) begin
            state_nxt = CBSC_WK_WAIT_DOM;
        end else if (filtered) begin
            case (state_r)
                CBSC_WK_WAIT_DOM: state_nxt = CBSC_WK_WAIT_REC;
                CBSC_WK_WAIT_REC: state_nxt = CBSC_WK_WAIT_DOM2;
                default: state_nxt = CBSC_WK_WAIT_DOM;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_r <= CBSC_WK_WAIT_DOM;
            cnt_r <= '0;
            wake_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wake_r <= done;
        end
    end

    assign o_wake = wake_r;

endmodule

// file: cbsc_top.sv
// Bus-bias state machine, transmit gating and receive mapping
`timescale 1ns/10ps
module cbsc_top
    import cbsc_pkg::*;
#(
    parameter int BUS_IDLE_TIMEOUT_CYCLES = CBSC_BUS_IDLE_TIMEOUT_CYCLES,
    parameter int WAKE_FILTER_CYCLES = CBSC_WAKE_FILTER_CYCLES
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire cbsc_mode_type I_MODE,
    input wire cbsc_supply_type I_SUPPLY,
    input wire logic I_TXD,
    input wire logic I_BUS_DOM_MAIN,
    input wire logic I_BUS_DOM_LP,
    output cbsc_bias_state_type O_STATE,
    output cbsc_bias_type O_BIAS,
    output cbsc_drive_type O_DRIVE,
    output logic O_RXD,
    output logic O_RXD_OE,
    output logic O_WAKE_PENDING,
    output logic O_TX_STUCK_LOW_BLOCK,
    output logic O_BUS_IDLE_TIMEOUT
);

    generate
        if (BUS_IDLE_TIMEOUT_CYCLES < 1 || WAKE_FILTER_CYCLES < 1) begin : g_bad
            $error("cbsc_top: timing counts must be at least one cycle");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Mode and supply decoding

    wire mode_normal = (I_MODE == CBSC_MODE_NORMAL);
    wire mode_silent = (I_MODE == CBSC_MODE_SILENT);
    wire mode_standby = (I_MODE == CBSC_MODE_STANDBY);
    wire mode_sleepish = (I_MODE == CBSC_MODE_GOTOSLEEP) || (I_MODE == CBSC_MODE_SLEEP);
    wire mode_online = mode_normal || mode_silent;
    wire mode_low_power = mode_standby || mode_sleepish;

    wire battery_low = I_SUPPLY.battery_uv_falling;
    wire battery_good = I_SUPPLY.battery_uv_rising;
    wire core_io_low = I_SUPPLY.core_supply_uv_falling || I_SUPPLY.io_supply_uv_falling;
    wire core_io_good = I_SUPPLY.core_supply_uv_rising && I_SUPPLY.io_supply_uv_rising && !core_io_low;
    wire io_present = !I_SUPPLY.io_supply_uv_falling;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    cbsc_bias_state_type state_r;
    cbsc_bias_state_type state_nxt;
    cbsc_bias_type bias_r;
    cbsc_bias_type bias_nxt;
    cbsc_drive_type drive_r;
    cbsc_drive_type drive_nxt;
    logic rxd_r;
    logic rxd_nxt;
    logic rxd_oe_r;
    logic rxd_oe_nxt;
    logic wake_pending_r;
    logic wake_pending_nxt;
    logic stuck_armed_r;
    logic stuck_armed_nxt;
    logic block_r;
    logic block_nxt;

    logic wake_event;
    logic idle_expired;

    ////////////////////////////////////////////////////////////////////////////
    // Wake pattern detector and idle timer

    wire wake_enable = mode_low_power && !battery_low;
    wire bus_activity = I_BUS_DOM_MAIN || I_BUS_DOM_LP || drive_r.dominant;

    cbsc_wake_detect #(
        .FILTER(WAKE_FILTER_CYCLES),
        .W($clog2(WAKE_FILTER_CYCLES + 1))
    ) u_wake (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_enable(wake_enable),
        .i_bus_dominant(I_BUS_DOM_LP),
        .o_wake(wake_event)
    );

    cbsc_idle_timer #(
        .CYCLES(BUS_IDLE_TIMEOUT_CYCLES),
        .W($clog2(BUS_IDLE_TIMEOUT_CYCLES + 1))
    ) u_idle (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_activity(bus_activity),
        .o_expired(idle_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bias state machine

    always_comb begin
        state_nxt = state_r;
        if (battery_low) begin
            state_nxt = CBSC_ST_OFF;
        end else begin
            case (state_r)
                CBSC_ST_OFF: begin
                    if (battery_good) begin
                        state_nxt = CBSC_ST_AUTO_INACT;
                    end
                end
                CBSC_ST_AUTO_INACT: begin
                    if (mode_online && core_io_good) begin
                        state_nxt = CBSC_ST_ACTIVE;
                    end else if (mode_online && core_io_low) begin
                        state_nxt = CBSC_ST_AUTO_ACT;
                    end else if (mode_low_power && wake_event) begin
                        state_nxt = CBSC_ST_AUTO_ACT;
                    end
                end
                CBSC_ST_AUTO_ACT: begin
                    if (mode_online && core_io_good) begin
                        state_nxt = CBSC_ST_ACTIVE;
                    end else if (mode_low_power && idle_expired) begin
                        state_nxt = CBSC_ST_AUTO_INACT;
                    end
                end
                CBSC_ST_ACTIVE: begin
                    if (mode_low_power) begin
                        state_nxt = idle_expired ? CBSC_ST_AUTO_INACT : CBSC_ST_AUTO_ACT;
                    end else if (core_io_low) begin
                        state_nxt = CBSC_ST_AUTO_ACT;
                    end
                end
                default: state_nxt = CBSC_ST_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bias network selection

    always_comb begin
        case (state_nxt)
            CBSC_ST_OFF: bias_nxt = CBSC_BIAS_FLOAT;
            CBSC_ST_AUTO_INACT: bias_nxt = CBSC_BIAS_GND;
            CBSC_ST_AUTO_ACT: bias_nxt = CBSC_BIAS_2V5;
            default: bias_nxt = CBSC_BIAS_HALF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stuck-low transmit input protection

    wire entering_active = (state_nxt == CBSC_ST_ACTIVE) && (state_r != CBSC_ST_ACTIVE);

    // Remembers a low transmit input seen while still in standby
    assign stuck_armed_nxt = mode_standby ? !I_TXD : (stuck_armed_r && !mode_online);

    // Block holds until the input returns high or the next state is no longer active
    assign block_nxt = (entering_active && stuck_armed_r) ? 1'b1 :
                       ((state_nxt != CBSC_ST_ACTIVE) || I_TXD) ? 1'b0 : block_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path

    wire tx_allowed = (state_nxt == CBSC_ST_ACTIVE) && mode_normal && !block_nxt;
    wire tx_dominant = tx_allowed && !I_TXD;

    assign drive_nxt.dominant = tx_dominant;
    assign drive_nxt.high_z = !tx_dominant;

    ////////////////////////////////////////////////////////////////////////////
    // Wake pending flag, cleared only by normal mode; the set wins

    assign wake_pending_nxt = wake_event || (wake_pending_r && !mode_normal);

    ////////////////////////////////////////////////////////////////////////////
    // Receive path

    // Own dominant drive shows as dominant even if the comparator lags
    wire bus_seen_dominant = I_BUS_DOM_MAIN || drive_r.dominant;
    wire rx_active = (state_nxt == CBSC_ST_ACTIVE) && mode_online && !block_nxt;

    always_comb begin
        rxd_nxt = 1'b1;
        rxd_oe_nxt = io_present && !battery_low;
        if (rx_active) begin
            rxd_nxt = !bus_seen_dominant;
        end else if (mode_standby) begin
            rxd_nxt = !wake_pending_nxt;
        end else if (mode_sleepish) begin
            rxd_nxt = 1'b1;
            rxd_oe_nxt = io_present && !battery_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and output flops

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            state_r <= CBSC_ST_OFF;
            bias_r <= CBSC_BIAS_FLOAT;
            drive_r <= 2'h1;
            rxd_r <= 1'b1;
            rxd_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bias_r <= bias_nxt;
            drive_r <= drive_nxt;
            rxd_r <= rxd_nxt;
            rxd_oe_r <= rxd_oe_nxt;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            wake_pending_r <= 1'b0;
            stuck_armed_r <= 1'b0;
            block_r <= 1'b0;
        end else begin
            wake_pending_r <= wake_pending_nxt;
            stuck_armed_r <= stuck_armed_nxt;
            block_r <= block_nxt;
        end
    end

    assign O_STATE = state_r;
    assign O_BIAS = bias_r;
    assign O_DRIVE = drive_r;
    assign O_RXD = rxd_r;
    assign O_RXD_OE = rxd_oe_r;
    assign O_WAKE_PENDING = wake_pending_r;
    assign O_TX_STUCK_LOW_BLOCK = block_r;
    assign O_BUS_IDLE_TIMEOUT = idle_expired;

endmodule

// file: cbsc_bus_model.sv
// Bus model: wired dominance of the own driver and of remote nodes
`timescale 1ns/10ps
module cbsc_bus_model
    import cbsc_pkg::*;
(
    input wire cbsc_drive_type i_drive,
    input wire logic i_remote_dom,
    output logic o_dom_main,
    output logic o_dom_lp
);
    // Dominant from any node wins the shared bus
    wire logic bus_dom = i_drive.dominant | i_remote_dom;
    assign o_dom_main = bus_dom;
    assign o_dom_lp = bus_dom;
endmodule

// file: cbsc_top_chk.sv
// Concurrent assertions on the ports of the bus-bias state control
`timescale 1ns/10ps
module cbsc_top_chk
    import cbsc_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire cbsc_mode_type I_MODE,
    input wire cbsc_supply_type I_SUPPLY,
    input wire logic I_TXD,
    input wire logic I_BUS_DOM_MAIN,
    input wire logic I_BUS_DOM_LP,
    input wire cbsc_bias_state_type O_STATE,
    input wire cbsc_bias_type O_BIAS,
    input wire cbsc_drive_type O_DRIVE,
    input wire logic O_RXD,
    input wire logic O_RXD_OE,
    input wire logic O_WAKE_PENDING,
    input wire logic O_TX_STUCK_LOW_BLOCK,
    input wire logic O_BUS_IDLE_TIMEOUT
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    wire logic bat = !I_SUPPLY.battery_uv_falling;
    wire logic fall = I_SUPPLY.core_supply_uv_falling | I_SUPPLY.io_supply_uv_falling;
    wire logic good = I_SUPPLY.core_supply_uv_rising & I_SUPPLY.io_supply_uv_rising & !fall;
    wire logic lp = I_MODE inside {CBSC_MODE_STANDBY, CBSC_MODE_GOTOSLEEP, CBSC_MODE_SLEEP};
    wire logic act = O_STATE == CBSC_ST_ACTIVE;
    ////////////////////////////////////////////////////////////////////////
    property p_off; !bat |=> O_STATE == CBSC_ST_OFF && O_BIAS == CBSC_BIAS_FLOAT; endproperty
    a_off: assert property (p_off) else $error("off state missed");
    property p_wake; $rose(O_WAKE_PENDING) |-> O_STATE == CBSC_ST_AUTO_ACT && O_BIAS == CBSC_BIAS_2V5; endproperty
    a_wake: assert property (p_wake) else $error("wake without bias");
    property p_idle; bat && lp && O_BUS_IDLE_TIMEOUT && O_STATE == CBSC_ST_AUTO_ACT
        |=> O_STATE == CBSC_ST_AUTO_INACT && O_BIAS == CBSC_BIAS_GND; endproperty
    a_idle: assert property (p_idle) else $error("idle return missed");
    property p_leave; bat && lp && act
        |=> O_STATE == ($past(O_BUS_IDLE_TIMEOUT) ? CBSC_ST_AUTO_INACT : CBSC_ST_AUTO_ACT); endproperty
    a_leave: assert property (p_leave) else $error("wrong low-power state");
    property p_drop; bat && !lp && fall && act |=> O_STATE == CBSC_ST_AUTO_ACT; endproperty
    a_drop: assert property (p_drop) else $error("supply drop ignored");
    property p_enter; bat && I_MODE == CBSC_MODE_NORMAL && good && O_STATE inside {CBSC_ST_AUTO_INACT, CBSC_ST_AUTO_ACT}
        |=> act; endproperty
    a_enter: assert property (p_enter) else $error("active not entered");
    property p_tx; bat && I_MODE == CBSC_MODE_NORMAL && good && !I_TXD && act && !O_TX_STUCK_LOW_BLOCK
        |=> O_DRIVE == 2'h2; endproperty
    a_tx: assert property (p_tx) else $error("dominant not driven");
    property p_quiet; I_MODE != CBSC_MODE_NORMAL |=> O_DRIVE == 2'h1; endproperty
    a_quiet: assert property (p_quiet) else $error("driver on outside normal");
    property p_block; O_TX_STUCK_LOW_BLOCK |-> O_DRIVE == 2'h1 && O_RXD; endproperty
    a_block: assert property (p_block) else $error("blocked path active");
    property p_rx; act && !O_TX_STUCK_LOW_BLOCK && $past(I_BUS_DOM_MAIN) |-> !O_RXD; endproperty
    a_rx: assert property (p_rx) else $error("dominant not received");
    property p_stby; bat && I_MODE == CBSC_MODE_STANDBY |=> O_RXD == !O_WAKE_PENDING; endproperty
    a_stby: assert property (p_stby) else $error("standby receive wrong");
    c_wake: cover property ($rose(O_WAKE_PENDING));
    c_block: cover property ($rose(O_TX_STUCK_LOW_BLOCK));
    c_idle: cover property ($rose(O_BUS_IDLE_TIMEOUT));
endmodule

bind cbsc_top cbsc_top_chk cbsc_top_chk_inst (.I_CLOCK, .I_RESET_N, .I_MODE, .I_SUPPLY, .I_TXD,
    .I_BUS_DOM_MAIN, .I_BUS_DOM_LP, .O_STATE, .O_BIAS, .O_DRIVE, .O_RXD, .O_RXD_OE, .O_WAKE_PENDING,
    .O_TX_STUCK_LOW_BLOCK, .O_BUS_IDLE_TIMEOUT);

// file: testbench.sv
// Self-checking testbench of the bus-bias state control
`timescale 1ns/10ps
module testbench
    import cbsc_pkg::*;
;
    typedef struct {
        logic [2:0] m;
        logic [5:0] s;
        logic t;
        logic d;
        int n;
        logic [3:0] st;
        logic dom;
        logic rxd;
        logic oe;
    } cbsc_row_type;
    localparam logic [5:0] sup_ok = 6'h15;
    localparam logic [5:0] sup_bat = 6'h25;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    cbsc_mode_type mode = CBSC_MODE_STANDBY;
    cbsc_supply_type supply = sup_bat;
    logic txd = 1'h1;
    logic remote = 1'h0;
    wire logic dom_main;
    wire logic dom_lp;
    cbsc_bias_state_type state;
    cbsc_bias_type bias;
    cbsc_drive_type drive;
    logic rxd, rxd_oe, wake, block, idle;
    int errors = 0;
    int cmp_count = 0;
    // Mode, supply, txd, remote, edges, then state, dominant, rxd, rxd enable
    cbsc_row_type rows [13] = '{
        '{3'h2, sup_bat, 1'h1, 1'h0, 2, 4'h1, 1'h0, 1'h1, 1'h0},
        '{3'h2, sup_ok, 1'h1, 1'h0, 2, 4'h2, 1'h0, 1'h1, 1'h1},
        '{3'h0, 6'h19, 1'h1, 1'h0, 2, 4'h4, 1'h0, 1'h1, 1'h1},
        '{3'h0, sup_ok, 1'h1, 1'h0, 2, 4'h8, 1'h0, 1'h1, 1'h1},
        '{3'h0, sup_ok, 1'h0, 1'h0, 2, 4'h8, 1'h1, 1'h0, 1'h1},
        '{3'h0, sup_ok, 1'h1, 1'h1, 2, 4'h8, 1'h0, 1'h0, 1'h1},
        '{3'h1, sup_ok, 1'h0, 1'h0, 2, 4'h8, 1'h0, 1'h1, 1'h1},
        '{3'h1, 6'h16, 1'h1, 1'h0, 2, 4'h4, 1'h0, 1'h1, 1'h0},
        '{3'h0, sup_ok, 1'h1, 1'h0, 2, 4'h8, 1'h0, 1'h1, 1'h1},
        '{3'h2, sup_ok, 1'h1, 1'h0, 2, 4'h4, 1'h0, 1'h1, 1'h1},
        '{3'h4, sup_ok, 1'h1, 1'h0, 8, 4'h2, 1'h0, 1'h1, 1'h1},
        '{3'h0, sup_ok, 1'h1, 1'h0, 2, 4'h8, 1'h0, 1'h1, 1'h1},
        '{3'h3, sup_ok, 1'h1, 1'h0, 2, 4'h2, 1'h0, 1'h1, 1'h1}};

    cbsc_top #(.BUS_IDLE_TIMEOUT_CYCLES(12), .WAKE_FILTER_CYCLES(3)) cbsc_top_inst (.I_CLOCK(clock),
        .I_RESET_N(reset_n), .I_MODE(mode), .I_SUPPLY(supply), .I_TXD(txd), .I_BUS_DOM_MAIN(dom_main),
        .I_BUS_DOM_LP(dom_lp), .O_STATE(state), .O_BIAS(bias), .O_DRIVE(drive), .O_RXD(rxd),
        .O_RXD_OE(rxd_oe), .O_WAKE_PENDING(wake), .O_TX_STUCK_LOW_BLOCK(block), .O_BUS_IDLE_TIMEOUT(idle));
    cbsc_bus_model cbsc_bus_model_inst (.i_drive(drive), .i_remote_dom(remote), .o_dom_main(dom_main),
        .o_dom_lp(dom_lp));

    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(string n, logic [3:0] e, logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apply(logic [2:0] m, logic [5:0] s, logic t, logic d, int n);
        @(posedge clock);
        mode <= cbsc_mode_type'(m);
        supply <= s;
        txd <= t;
        remote <= d;
        repeat (n) @(posedge clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'h1;
        foreach (rows[i]) begin
            apply(rows[i].m, rows[i].s, rows[i].t, rows[i].d, rows[i].n);
            chk("state", rows[i].st, state);
            chk("bias", {rows[i].st[0], rows[i].st[1], rows[i].st[2], rows[i].st[3]}, bias);
            chk("drive", rows[i].dom ? 2'h2 : 2'h1, drive);
            chk("rxd", rows[i].rxd, rxd);
            chk("rxd_oe", rows[i].oe, rxd_oe);
        end
        // A level lasts n + 1 edges; two-edge burst must not count as a phase
        apply(3'h2, sup_ok, 1'h1, 1'h1, 1);
        apply(3'h2, sup_ok, 1'h1, 1'h0, 6);
        apply(3'h2, sup_ok, 1'h1, 1'h1, 4);
        chk("wake", 1'h0, wake);
        apply(3'h2, sup_ok, 1'h1, 1'h0, 4);
        apply(3'h2, sup_ok, 1'h1, 1'h1, 4);
        apply(3'h2, sup_ok, 1'h1, 1'h0, 3);
        chk("wake", 1'h1, wake);
        chk("state", CBSC_ST_AUTO_ACT, state);
        chk("bias", CBSC_BIAS_2V5, bias);
        chk("rxd", 1'h0, rxd);
        chk("idle", 1'h0, idle);
        apply(3'h2, sup_ok, 1'h1, 1'h0, 12);
        chk("idle", 1'h1, idle);
        chk("state", CBSC_ST_AUTO_INACT, state);
        chk("rxd", 1'h0, rxd);
        // Transmit input stuck low across the standby exit
        apply(3'h2, sup_ok, 1'h0, 1'h0, 3);
        chk("drive", 2'h1, drive);
        apply(3'h0, sup_ok, 1'h0, 1'h0, 2);
        chk("state", CBSC_ST_ACTIVE, state);
        chk("block", 1'h1, block);
        chk("drive", 2'h1, drive);
        chk("wake", 1'h0, wake);
        apply(3'h0, sup_ok, 1'h0, 1'h1, 2);
        chk("rxd", 1'h1, rxd);
        apply(3'h0, sup_ok, 1'h1, 1'h1, 2);
        chk("block", 1'h0, block);
        chk("rxd", 1'h0, rxd);
        // Battery loss overrides the active state at once
        apply(3'h0, sup_bat, 1'h1, 1'h0, 1);
        chk("state", CBSC_ST_OFF, state);
        chk("rxd_oe", 1'h0, rxd_oe);
        apply(3'h0, sup_ok, 1'h1, 1'h0, 3);
        chk("state", CBSC_ST_ACTIVE, state);
        // Reset in mid-run
        @(posedge clock);
        reset_n <= 1'h0;
        @(posedge clock);
        #1;
        chk("state", CBSC_ST_OFF, state);
        chk("drive", 2'h1, drive);
        chk("rxd_oe", 1'h0, rxd_oe);
        chk("idle", 1'h0, idle);
        @(posedge clock);
        reset_n <= 1'h1;
        @(posedge clock);
        #1;
        chk("state", CBSC_ST_AUTO_INACT, state);
        @(posedge clock);
        #1;
        chk("state", CBSC_ST_ACTIVE, state);
        give_verdict();
    end
endmodule
